//--- lt_pkg.sv
// package: types and constants of the line-termination activation machine
// Contract
// - Deactivated: send SIG 0; leave only on FE 1, FE 9 or SIG 1W.
// - SIG 1W when deactivated: start Tl1, issue FE 2, go 1.2, send SIG 2W.
// - In 1.2 new SIG 1W restarts Tl1; Tl1 expiry goes 1.4 sending SIG 2.
// - FE 1 when deactivated: go 1.3 sending SIG 2W; SIG 1W then goes 1.4.
// - In 1.4 send SIG 2; synchronized with SIG 1 issues FE 3, goes 1.5.
// - 1.5 sends SIG 2; SIG 3 in 1.4 or 1.5 starts Tl2, goes 1.6.
// - In 1.6 send SIG 4H until Tl2 expires, then go fully active.
// - In 1.7 send SIG 4, issue FE 4; channels carry traffic.
// - FE 5 outside 1.1 and 1.8 goes 1.8 and sends SIG 0.
// - In 1.8 received SIG 0 issues FE 6 and returns to 1.1.
// - FE 9 starts Tl4, goes 2.1 sending SIG 2W; Tl4 expiry goes 2.2 sending SIG 2.
// - In 2.2 loopback 1 operated; loop sync starts Tl2, goes 2.3.
// - In 2.3 send SIG 4H until Tl2 expires, then issue FE 4, go 2.4.
// - In 2.4 fully active with loopback 1, sending SIG 4.
// - Loopback 2 and 1A requests only relayed; state machine untouched.
// - Activation after deactivation completes within 210 ms, 420 ms with regenerator.
// - Activation after first powering completes within 1,5 s, 3 s with regenerator.
package lt_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 12;
    localparam logic [11:0] TL1_MS = 12'h006;
    localparam logic [11:0] TL2_MS = 12'h006;
    localparam logic [11:0] TL4_MS = 12'h006;
    localparam logic [11:0] ACT_MS = 12'h0D2;
    localparam logic [11:0] ACT_REG_MS = 12'h1A4;
    localparam logic [11:0] ACT_PWR_MS = 12'h5DC;
    localparam logic [11:0] ACT_PWR_REG_MS = 12'hBB8;

    // ==========================================================
    // states, one-hot
    typedef enum logic [11:0] {
        LT_ST11 = 12'h001,
        LT_ST12 = 12'h002,
        LT_ST13 = 12'h004,
        LT_ST14 = 12'h008,
        LT_ST15 = 12'h010,
        LT_ST16 = 12'h020,
        LT_ST17 = 12'h040,
        LT_ST18 = 12'h080,
        LT_ST21 = 12'h100,
        LT_ST22 = 12'h200,
        LT_ST23 = 12'h400,
        LT_ST24 = 12'h800
    } lt_state_t;

    // ==========================================================
    // line transmit signals
    typedef enum logic [2:0] {
        LT_TX_SIG0 = 3'h0,
        LT_TX_SIG2W = 3'h1,
        LT_TX_SIG2 = 3'h2,
        LT_TX_SIG4H = 3'h3,
        LT_TX_SIG4 = 3'h4
    } lt_tx_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic fe1;
        logic fe5;
        logic fe9;
    } lt_fe_req_t;

    typedef struct packed {
        logic sig0;
        logic sig1w;
        logic sig1;
        logic sig3;
        logic sync;
        logic frame_lost;
        logic loop_sync;
    } lt_rx_ev_t;

    typedef struct packed {
        logic fe2;
        logic fe3;
        logic fe4;
        logic fe6;
        logic fe7;
    } lt_fe_ind_t;

endpackage : lt_pkg

//--- lt_ms_timer.sv
// file: millisecond down-counter timer driven by a tick enable
`timescale 1ns/1ns
`default_nettype none
module lt_ms_timer
    import lt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic [TMR_W-1:0] load,
    output logic running,
    output logic expired
);
    logic [TMR_W-1:0] cnt_ff;
    logic run_ff;
    logic exp_ff;

    // ==========================================================
    // count down one per tick; restart on start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            exp_ff <= 1'b0;
        end else begin
            exp_ff <= 1'b0;
            if (start) begin
                cnt_ff <= (load == '0) ? TMR_W'(1) : load;
                run_ff <= 1'b1;
            end else if (stop) begin
                run_ff <= 1'b0;
            end else if (run_ff && tick) begin
                if (cnt_ff <= TMR_W'(1)) begin
                    run_ff <= 1'b0;
                    exp_ff <= 1'b1;
                end
                cnt_ff <= cnt_ff - TMR_W'(1);
            end
        end
    end

    assign running = run_ff;
    assign expired = exp_ff;

endmodule : lt_ms_timer
`default_nettype wire

//--- lt_line_act.sv
// file: line-termination activation and deactivation state machine
`timescale 1ns/1ns
`default_nettype none
module lt_line_act
    import lt_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire lt_fe_req_t fe_req,
    input wire lt_rx_ev_t rx_ev,
    input wire logic regen_present,
    input wire logic lb2_req,
    input wire logic lb1a_req,
    output lt_fe_ind_t fe_ind,
    output lt_tx_t tx_sig,
    output lt_state_t state,
    output logic lb1_operated,
    output logic chan_active,
    output logic act_timeout,
    output logic lb2_relay,
    output logic lb1a_relay
);

    // ==========================================================
    // helpers
    function automatic lt_tx_t tx_of(input lt_state_t s);
        case (s)
            LT_ST12, LT_ST13, LT_ST21: tx_of = LT_TX_SIG2W;
            LT_ST14, LT_ST15, LT_ST22: tx_of = LT_TX_SIG2;
            LT_ST16, LT_ST23: tx_of = LT_TX_SIG4H;
            LT_ST17, LT_ST24: tx_of = LT_TX_SIG4;
            default: tx_of = LT_TX_SIG0;
        endcase
    endfunction : tx_of

    function automatic logic is_lb1(input lt_state_t s);
        is_lb1 = (s == LT_ST22) || (s == LT_ST23) || (s == LT_ST24);
    endfunction : is_lb1

    function automatic logic is_up(input lt_state_t s);
        is_up = (s == LT_ST17) || (s == LT_ST24);
    endfunction : is_up

    // ==========================================================
    // millisecond tick divider
    logic [31:0] tick_cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= 32'(TICK_LEN - 1)) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
            tick_ff <= 1'b0;
        end
    end

    // ==========================================================
    // timers
    lt_state_t state_ff;
    lt_state_t nxt_state;
    lt_fe_ind_t nxt_fe;
    logic st_tl1;
    logic st_tl2;
    logic st_tl4;
    logic tl1_exp;
    logic tl2_exp;
    logic tl4_exp;
    logic act_run;
    logic act_exp;
    logic act_start;
    logic act_stop;
    logic first_pwr_ff;
    logic [TMR_W-1:0] act_load;

    lt_ms_timer u_tl1 (
        .clk(clk),
        .reset(reset),
        .tick(tick_ff),
        .start(st_tl1),
        .stop(nxt_state != LT_ST12),
        .load(TL1_MS),
        .running(),
        .expired(tl1_exp)
    );

    lt_ms_timer u_tl2 (
        .clk(clk),
        .reset(reset),
        .tick(tick_ff),
        .start(st_tl2),
        .stop((nxt_state != LT_ST16) && (nxt_state != LT_ST23)),
        .load(TL2_MS),
        .running(),
        .expired(tl2_exp)
    );

    lt_ms_timer u_tl4 (
        .clk(clk),
        .reset(reset),
        .tick(tick_ff),
        .start(st_tl4),
        .stop(nxt_state != LT_ST21),
        .load(TL4_MS),
        .running(),
        .expired(tl4_exp)
    );

    // activation supervision, limit chosen by regenerator and powering
    // limit after first powering or after deactivation
    always_comb begin
        if (first_pwr_ff) begin
            act_load = regen_present ? ACT_PWR_REG_MS : ACT_PWR_MS;
        end else begin
            act_load = regen_present ? ACT_REG_MS : ACT_MS;
        end
    end

    assign act_start = (state_ff == LT_ST11) && (nxt_state != LT_ST11);
    assign act_stop = is_up(nxt_state) || (nxt_state == LT_ST18) || (nxt_state == LT_ST11);

    lt_ms_timer u_act (
        .clk(clk),
        .reset(reset),
        .tick(tick_ff),
        .start(act_start),
        .stop(act_stop),
        .load(act_load),
        .running(act_run),
        .expired(act_exp)
    );

    // ==========================================================
    // transition logic; FE 5 has priority over every other event outside 1.1 and 1.8
    always_comb begin
        nxt_state = state_ff;
        nxt_fe = '0;
        st_tl1 = 1'b0;
        st_tl2 = 1'b0;
        st_tl4 = 1'b0;
        if (fe_req.fe5 && (state_ff != LT_ST11) && (state_ff != LT_ST18)) begin
            nxt_state = LT_ST18;
        end else begin
            case (state_ff)
                // leave idle only on request or wake-up
                LT_ST11: begin
                    if (fe_req.fe9) begin
                        st_tl4 = 1'b1;
                        nxt_state = LT_ST21;
                    end else if (fe_req.fe1) begin
                        nxt_state = LT_ST13;
                    end else if (rx_ev.sig1w) begin
                        st_tl1 = 1'b1;
                        nxt_fe.fe2 = 1'b1;
                        nxt_state = LT_ST12;
                    end
                end
                LT_ST12: begin
                    if (rx_ev.sig1w) begin
                        st_tl1 = 1'b1;
                    end else if (tl1_exp) begin
                        nxt_state = LT_ST14;
                    end
                end
                LT_ST13: begin
                    if (fe_req.fe9) begin
                        nxt_state = LT_ST22;
                    end else if (rx_ev.sig1w) begin
                        nxt_state = LT_ST14;
                    end
                end
                LT_ST14: begin
                    if (fe_req.fe9) begin
                        nxt_state = LT_ST22;
                    end else if (rx_ev.sig3) begin
                        st_tl2 = 1'b1;
                        nxt_state = LT_ST16;
                    end else if (rx_ev.sync && rx_ev.sig1) begin
                        nxt_fe.fe3 = 1'b1;
                        nxt_state = LT_ST15;
                    end
                end
                LT_ST15: begin
                    nxt_fe.fe7 = rx_ev.sig0 || rx_ev.frame_lost;
                    if (fe_req.fe9) begin
                        nxt_state = LT_ST22;
                    end else if (rx_ev.sig3) begin
                        st_tl2 = 1'b1;
                        nxt_state = LT_ST16;
                    end
                end
                LT_ST16: begin
                    nxt_fe.fe7 = rx_ev.sig0 || rx_ev.frame_lost;
                    if (tl2_exp) begin
                        nxt_fe.fe4 = 1'b1;
                        nxt_state = LT_ST17;
                    end
                end
                LT_ST17: begin
                    nxt_fe.fe7 = rx_ev.sig0 || rx_ev.frame_lost;
                end
                LT_ST18: begin
                    if (fe_req.fe9) begin
                        st_tl4 = 1'b1;
                        nxt_state = LT_ST21;
                    end else if (rx_ev.sig0) begin
                        nxt_fe.fe6 = 1'b1;
                        nxt_state = LT_ST11;
                    end
                end
                LT_ST21: begin
                    if (tl4_exp) begin
                        nxt_state = LT_ST22;
                    end
                end
                LT_ST22: begin
                    if (rx_ev.loop_sync) begin
                        st_tl2 = 1'b1;
                        nxt_state = LT_ST23;
                    end
                end
                LT_ST23: begin
                    if (tl2_exp) begin
                        nxt_fe.fe4 = 1'b1;
                        nxt_state = LT_ST24;
                    end
                end
                LT_ST24: nxt_state = LT_ST24;
                // illegal code, back to idle
                default: nxt_state = LT_ST11;
            endcase
        end
    end

    // ==========================================================
    // state and indications
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= LT_ST11;
        end else begin
            state_ff <= nxt_state;
        end
    end

    lt_fe_ind_t fe_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fe_ff <= '0;
        end else begin
            fe_ff <= nxt_fe;
        end
    end

    lt_tx_t tx_ff;
    logic lb1_ff;
    logic up_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_ff <= LT_TX_SIG0;
            lb1_ff <= 1'b0;
            up_ff <= 1'b0;
        end else begin
            tx_ff <= tx_of(nxt_state);
            lb1_ff <= is_lb1(nxt_state);
            up_ff <= is_up(nxt_state);
        end
    end

    // overrun flag, held until the next activation starts
    // first powering long limit used until the first full activation
    logic tout_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tout_ff <= 1'b0;
            first_pwr_ff <= 1'b1;
        end else begin
            if (act_exp) begin
                tout_ff <= 1'b1;
            end else if (act_start) begin
                tout_ff <= 1'b0;
            end
            if (is_up(nxt_state)) begin
                first_pwr_ff <= 1'b0;
            end
        end
    end

    // loopback 2 and 1A relayed only
    logic lb2_ff;
    logic lb1a_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lb2_ff <= 1'b0;
            lb1a_ff <= 1'b0;
        end else begin
            lb2_ff <= lb2_req;
            lb1a_ff <= lb1a_req;
        end
    end

    assign state = state_ff;
    assign fe_ind = fe_ff;
    assign tx_sig = tx_ff;
    assign lb1_operated = lb1_ff;
    assign chan_active = up_ff;
    assign act_timeout = tout_ff;
    assign lb2_relay = lb2_ff;
    assign lb1a_relay = lb1a_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_wake;
        state_ff == LT_ST11 && rx_ev.sig1w && !fe_req.fe1 && !fe_req.fe9;
    endsequence

    sequence s_wake_done;
        state_ff == LT_ST12 && fe_ff.fe2 && tx_ff == LT_TX_SIG2W;
    endsequence

    a_wake_answer: assert property (s_wake |=> s_wake_done)
        else $error("wake-up not answered");

    a_idle_silent: assert property (state_ff == LT_ST11 |-> tx_ff == LT_TX_SIG0)
        else $error("idle line not silent");

    a_fe5_deact: assert property (fe_req.fe5 && state_ff != LT_ST11 && state_ff != LT_ST18
        |=> state_ff == LT_ST18 && tx_ff == LT_TX_SIG0)
        else $error("deactivation request ignored");

    a_pend_idle: assert property (state_ff == LT_ST18 && rx_ev.sig0 && !fe_req.fe9
        |=> state_ff == LT_ST11 && fe_ff.fe6)
        else $error("pending deactivation did not end");

    a_tl1_step: assert property (state_ff == LT_ST12 && tl1_exp && !rx_ev.sig1w && !fe_req.fe5
        |=> state_ff == LT_ST14 && tx_ff == LT_TX_SIG2)
        else $error("Tl1 expiry not taken");

    a_fe7_keep: assert property (fe_ff.fe7 |-> $stable(state_ff) || $past(fe_req.fe5)
        || $past(rx_ev.sig3) || $past(tl2_exp) || $past(fe_req.fe9))
        else $error("FE 7 moved the state");

    a_lb_active: assert property (state_ff == LT_ST23 && tl2_exp && !fe_req.fe5
        |=> state_ff == LT_ST24 && fe_ff.fe4 && lb1_operated && tx_ff == LT_TX_SIG4)
        else $error("loopback 1 not activated");

    a_sync_fe3: assert property (state_ff == LT_ST14 && rx_ev.sync && rx_ev.sig1 && !rx_ev.sig3
        && !fe_req.fe5 && !fe_req.fe9 |=> fe_ff.fe3 && state_ff == LT_ST15)
        else $error("FE 3 missing after sync");

    a_lb2_relay: assert property (lb2_req && state_ff == LT_ST17 && !fe_req.fe5
        |=> lb2_relay && state_ff == LT_ST17)
        else $error("loopback 2 relay wrong");

endmodule : lt_line_act
`default_nettype wire

//--- lt_nt1_model.sv
// file: behavioural far-end line transceiver facing the termination
`timescale 1ns/1ns
`default_nettype none
module lt_nt1_model
    import lt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire lt_tx_t tx_sig,
    input wire logic wake,
    input wire logic drop,
    input wire logic lose_frame,
    input wire logic loop_mode,
    input wire logic [7:0] dly,
    output lt_rx_ev_t rx_ev
);
    logic [7:0] cnt_ff;
    lt_tx_t last_tx_ff;
    logic seen;
    logic lock;

    // ==========================================================
    // cycles since the transmit code last changed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 8'h00;
            last_tx_ff <= LT_TX_SIG0;
        end else begin
            last_tx_ff <= tx_sig;
            if (tx_sig != last_tx_ff) begin
                cnt_ff <= 8'h00;
            end else if (cnt_ff != 8'hFF) begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // ==========================================================
    // answers after dly cycles, SIG 3 after twice dly
    // answer time set by dly
    assign seen = (cnt_ff == dly);
    assign lock = (cnt_ff >= dly) && ((cnt_ff - dly) < dly);
    always_comb begin
        rx_ev = '0;
        rx_ev.sig1w = wake | (tx_sig == LT_TX_SIG2W && seen && !loop_mode);
        rx_ev.sync = tx_sig == LT_TX_SIG2 && lock && !loop_mode;
        rx_ev.sig1 = rx_ev.sync;
        rx_ev.sig3 = tx_sig == LT_TX_SIG2 && cnt_ff == (dly + dly) && !loop_mode;
        rx_ev.loop_sync = loop_mode && tx_sig == LT_TX_SIG2 && seen;
        rx_ev.sig0 = drop | (tx_sig == LT_TX_SIG0 && seen);
        rx_ev.frame_lost = lose_frame;
    end
endmodule : lt_nt1_model
`default_nettype wire

//--- tb_top.sv
// file: self-checking bench for the activation state machine
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import lt_pkg::*;
;
    localparam int TB_TICK = 4;

    typedef struct packed {
        lt_state_t st;
        lt_tx_t tx;
        lt_fe_ind_t fe;
    } lt_note_t;

    logic clk, reset, regen_present, lb2_req, lb1a_req, rnd_on;
    logic lb1_operated, chan_active, act_timeout, lb2_relay, lb1a_relay;
    logic wake, drop, lose_frame, loop_mode, prev_lb2, prev_lb1a;
    logic [7:0] dly;
    lt_fe_req_t fe_req;
    lt_rx_ev_t rx_ev;
    lt_fe_ind_t fe_ind;
    lt_tx_t tx_sig;
    lt_state_t state;
    lt_state_t last_st;
    lt_note_t notes[$];
    int err_count, n_compared;

    lt_line_act #(.TICK_LEN(TB_TICK)) lt_line_act_i (.clk(clk), .reset(reset), .fe_req(fe_req), .rx_ev(rx_ev),
        .regen_present(regen_present), .lb2_req(lb2_req), .lb1a_req(lb1a_req), .fe_ind(fe_ind),
        .tx_sig(tx_sig), .state(state), .lb1_operated(lb1_operated), .chan_active(chan_active),
        .act_timeout(act_timeout), .lb2_relay(lb2_relay), .lb1a_relay(lb1a_relay));
    lt_nt1_model lt_nt1_model_i (.clk(clk), .reset(reset), .tx_sig(tx_sig), .wake(wake), .drop(drop),
        .lose_frame(lose_frame), .loop_mode(loop_mode), .dly(dly), .rx_ev(rx_ev));

    // ==========================================================
    // tasks
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_vec(input string name, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : cmp_vec

    task automatic note(input lt_state_t s, input lt_tx_t t, input logic [4:0] f);
        notes.push_back('{s, t, lt_fe_ind_t'(f)});
    endtask : note

    task automatic send_req(input logic [2:0] r);
        @(posedge clk);
        #1 fe_req = lt_fe_req_t'(r);
        @(posedge clk);
        #1 fe_req = '0;
    endtask : send_req

    task automatic line_pulse(input logic [2:0] m);
        @(posedge clk);
        #1 {wake, drop, lose_frame} = m;
        @(posedge clk);
        #1 {wake, drop, lose_frame} = 3'h0;
    endtask : line_pulse

    task automatic expect_act(input lt_state_t first);
        note(first, LT_TX_SIG2W, first == LT_ST12 ? 5'h10 : 5'h00);
        note(LT_ST14, LT_TX_SIG2, 5'h00);
        note(LT_ST15, LT_TX_SIG2, 5'h08);
        note(LT_ST16, LT_TX_SIG4H, 5'h00);
        note(LT_ST17, LT_TX_SIG4, 5'h04);
    endtask : expect_act

    task automatic deactivate;
        note(LT_ST18, LT_TX_SIG0, 5'h00);
        note(LT_ST11, LT_TX_SIG0, 5'h02);
        send_req(3'h2);
    endtask : deactivate

    task automatic drain(input int lim);
        int i;
        i = 0;
        while (notes.size() != 0 && i < lim) begin
            @(posedge clk);
            i++;
        end
        if (notes.size() != 0) begin
            err_count++;
            $display("BAD pending notes expected 0 seen %0d", notes.size());
            notes.delete();
        end
        repeat (8) @(posedge clk);
        #1;
    endtask : drain

    task automatic wait_tout(input int lim);
        int i;
        repeat (lim - 8) @(posedge clk);
        #1 cmp_vec("act_timeout early", 12'h000, 12'(act_timeout));
        i = 0;
        while (act_timeout !== 1'b1 && i < 40) begin
            @(posedge clk);
            #1;
            i++;
        end
        cmp_vec("act_timeout late", 12'h001, 12'(act_timeout));
    endtask : wait_tout

    // ==========================================================
    // clock, random loopback requests, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        #1;
        if (rnd_on) begin
            lb2_req = 1'($urandom);
            lb1a_req = 1'($urandom);
        end
    end

    initial begin
        #(4 * 40000);
        err_count++;
        print_verdict();
    end

    // ==========================================================
    // monitor: every result takes the oldest note
    always @(negedge clk) begin : monitor
        lt_note_t nt;
        if (!reset && (state !== last_st || fe_ind !== 5'h00)) begin
            if (notes.size() == 0) begin
                err_count++;
                $display("BAD result expected none seen %h %h", state, fe_ind);
            end else begin
                nt = notes.pop_front();
                cmp_vec("state", 12'(nt.st), 12'(state));
                cmp_vec("tx_sig", 12'(nt.tx), 12'(tx_sig));
                cmp_vec("fe_ind", 12'(nt.fe), 12'(fe_ind));
                cmp_vec("chan_active", 12'(nt.st == LT_ST17 || nt.st == LT_ST24), 12'(chan_active));
                cmp_vec("lb1_operated", 12'(nt.st inside {LT_ST22, LT_ST23, LT_ST24}), 12'(lb1_operated));
            end
        end
        if (!reset) begin
            cmp_vec("lb2_relay", 12'(prev_lb2), 12'(lb2_relay));
            cmp_vec("lb1a_relay", 12'(prev_lb1a), 12'(lb1a_relay));
        end
        last_st = state;
        prev_lb2 = lb2_req;
        prev_lb1a = lb1a_req;
    end

    // ==========================================================
    // main sequence
    initial begin
        {reset, regen_present, lb2_req, lb1a_req, rnd_on, wake, drop, lose_frame} = 8'h80;
        fe_req = '0;
        loop_mode = 1'b1;
        dly = 8'h02;
        last_st = LT_ST11;
        err_count = 0;
        n_compared = 0;
        void'($urandom(58780));
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        rnd_on = 1'b1;
        // far end mute: supervision limit of first powering runs out
        note(LT_ST13, LT_TX_SIG2W, 5'h00);
        send_req(3'h4);
        wait_tout(int'(ACT_PWR_MS) * TB_TICK);
        deactivate();
        drain(100);
        // refused FE 5 while deactivated, then slow far end; FE 1 and FE 9 refused in 1.7
        loop_mode = 1'b0;
        dly = 8'h09;
        regen_present = 1'($urandom);
        send_req(3'h2);
        drain(20);
        expect_act(LT_ST13);
        send_req(3'h4);
        drain(300);
        cmp_vec("act_timeout cleared", 12'h000, 12'(act_timeout));
        note(LT_ST17, LT_TX_SIG4, 5'h01);
        note(LT_ST17, LT_TX_SIG4, 5'h01);
        line_pulse(3'h2);
        line_pulse(3'h1);
        send_req(3'h4);
        send_req(3'h1);
        drain(50);
        deactivate();
        drain(100);
        // prompt far end wakes the line
        dly = 8'h02;
        expect_act(LT_ST12);
        line_pulse(3'h4);
        drain(300);
        deactivate();
        drain(100);
        // abort while waiting in 1.2
        dly = 8'h09;
        note(LT_ST12, LT_TX_SIG2W, 5'h10);
        line_pulse(3'h4);
        repeat (2) @(posedge clk);
        deactivate();
        drain(100);
        // far end mute after a deactivation: short limit runs out
        loop_mode = 1'b1;
        note(LT_ST13, LT_TX_SIG2W, 5'h00);
        send_req(3'h4);
        wait_tout(regen_present ? int'(ACT_REG_MS) * TB_TICK : int'(ACT_MS) * TB_TICK);
        deactivate();
        drain(100);
        // loopback 1 activation
        loop_mode = 1'b1;
        note(LT_ST21, LT_TX_SIG2W, 5'h00);
        note(LT_ST22, LT_TX_SIG2, 5'h00);
        note(LT_ST23, LT_TX_SIG4H, 5'h00);
        note(LT_ST24, LT_TX_SIG4, 5'h04);
        send_req(3'h1);
        drain(300);
        deactivate();
        drain(100);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
